/* hdl/efs_pkg.sv */
// Package of constants for the ECP FIFO service and configuration block
package efs_pkg;
  // Host I/O offsets (FIFO and configuration ports)
  localparam logic [10:0] DATA_FIFO_OFS = 11'h400;
  localparam logic [10:0] CMD_FIFO_OFS = 11'h000;
  localparam logic [10:0] CFG_INDEX_OFS = 11'h404;
  localparam logic [10:0] CFG_DATA_OFS = 11'h405;
  // Configuration keys
  localparam logic [7:0] CFG_ENTER_KEY = 8'h78;
  localparam logic [7:0] CFG_EXIT_KEY = 8'haa;
  // Configuration register indices
  localparam logic [7:0] IDX_CHIP_IDENT_FIRST = 8'h20;
  localparam logic [7:0] IDX_CHIP_IDENT_SECOND = 8'h21;
  localparam logic [7:0] IDX_PORT_MODE_CONTROL = 8'hf0;
  // Identification values, arbitrary
  localparam logic [7:0] CHIP_IDENT_FIRST_VAL = 8'h5a;
  localparam logic [7:0] CHIP_IDENT_SECOND_VAL = 8'h0c;
  // Mode control layout and reset
  localparam logic [7:0] PORT_MODE_CONTROL_RST = 8'h3f;
  localparam int IRQ_TYPE_BIT = 7;
  localparam int THR_LSB = 3;
  localparam int THR_MSB = 6;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  typedef enum logic [2:0] {
    EFS_MODE_SPP = 3'b000,
    EFS_MODE_EPP19 = 3'b001,
    EFS_MODE_ECP = 3'b010,
    EFS_MODE_ECP_EPP19 = 3'b011,
    EFS_MODE_PRINTER = 3'b100,
    EFS_MODE_EPP17 = 3'b101,
    EFS_MODE_RSVD = 3'b110,
    EFS_MODE_ECP_EPP17 = 3'b111
  } efs_mode_t;
  // FIFO geometry and service levels
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_FULL_COUNT = 5'h10;
  localparam logic [4:0] THR_CAP = 5'h0f;
  // DMA burst limit and idle time
  localparam logic [5:0] DMA_BURST_MAX = 6'h20;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int DACK_IDLE_NS = 350;
  localparam int DACK_IDLE_CYC = (DACK_IDLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Interrupt low pulse length in cycles
  localparam int IRQ_PULSE_CYC = 4;
endpackage

/* hdl/efs_fifo.sv */
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/100ps
module efs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // efs_fifo

/* hdl/efs_service.sv */
// FIFO service logic, DMA and interrupt requests, and configuration port
// Function
// - Reverse DMA requests while FIFO holds data
// - Drop request on empty or acknowledged TC
// - Last byte: drop on acknowledge or read
// - Re-request once a byte returns after empty
// - After TC wait for byte and mask clear
// - PIO: mask and DMA clear enable interrupt
// - Data FIFO at 400H, command at 000H
// - Threshold sixteen treated as fifteen
// - Reverse interrupt at count >= 16-threshold
// - Forward interrupt at count <= threshold
// - Config via index 404H, data 405H
// - Key 78H twice enters configuration mode
// - AAH to index leaves configuration mode
// - Two read-only chip identification registers
// - Three-bit mode field, reset 111
// - Threshold field in bits six to three
// - Interrupt type: pulse or follow ACK
// - Mask set blocks; clear fires at once
// - Field is effective threshold minus one
// - At most 32 DMA cycles, then 350ns idle
// - TC raises interrupt and sets mask
`timescale 1ns/100ps
module efs_service
  import efs_pkg::*;
#(
  parameter int FIFO_WORDS = 8
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic [10:0] HOST_ADDR,
  input wire logic [7:0] HOST_WDATA,
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  output logic [7:0] HOST_RDATA,
  input wire logic DMA_ACKNOWLEDGE_N,
  input wire logic TERMINAL_COUNT_IN,
  output logic DMA_REQUEST_OUT,
  input wire logic DMA_TRANSFER_ENABLE,
  input wire logic SERVICE_IRQ_MASK_CLR,
  input wire logic SERVICE_IRQ_MASK_SET,
  output logic SERVICE_IRQ_MASK,
  input wire logic DIRECTION_REVERSE,
  input wire logic ACK_N,
  output logic PORT_INTERRUPT_OUT,
  output logic PORT_INTERRUPT_OE,
  input wire logic [7:0] PERIPH_DATA,
  input wire logic PERIPH_VALID,
  output logic PERIPH_READY,
  output logic [7:0] FWD_DATA,
  output logic FWD_VALID,
  output logic FWD_IS_COMMAND,
  input wire logic FWD_READY,
  output logic [2:0] PORT_MODE
);
  logic [7:0] port_mode_control;
  logic cfg_mode;
  logic key_seen;
  logic [7:0] cfg_index;
  logic service_irq_mask;
  logic tc_block;
  logic [5:0] burst_cnt;
  logic burst_hold;
  logic [7:0] idle_cnt;
  logic dack_q;
  logic ack_q;
  logic [2:0] pulse_cnt;
  logic svc_q;
  logic periph_ready;
  logic [7:0] fifo_in_data;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [$clog2(FIFO_WORDS):0] fifo_count;
  logic cmd_pending;
  logic [4:0] eff_thr;
  logic [4:0] level;
  logic svc_cond;
  logic dack;
  logic tc_hit;
  logic host_data_rd;
  logic host_data_wr;
  logic host_cmd_wr;
  logic dma_dreq;

  function automatic logic [7:0] cfg_read(input logic [7:0] idx, input logic [7:0] pmc);
    unique case (idx)
      IDX_CHIP_IDENT_FIRST: cfg_read = CHIP_IDENT_FIRST_VAL;
      IDX_CHIP_IDENT_SECOND: cfg_read = CHIP_IDENT_SECOND_VAL;
      IDX_PORT_MODE_CONTROL: cfg_read = pmc;
      default: cfg_read = 8'h00;
    endcase
  endfunction

  assign dack = !DMA_ACKNOWLEDGE_N;
  assign host_data_rd = HOST_RD && (HOST_ADDR == DATA_FIFO_OFS);
  assign host_data_wr = HOST_WR && (HOST_ADDR == DATA_FIFO_OFS);
  assign host_cmd_wr = HOST_WR && (HOST_ADDR == CMD_FIFO_OFS);
  assign tc_hit = TERMINAL_COUNT_IN && dack;

  // Effective threshold is field plus one, sixteen capped to fifteen
  always_comb begin
    eff_thr = 5'(port_mode_control[THR_MSB:THR_LSB]) + 5'h01;
    if (eff_thr > THR_CAP) begin
      eff_thr = THR_CAP;
    end
    level = 5'(fifo_count);
  end

  // Service condition for programmed I/O
  always_comb begin
    if (DIRECTION_REVERSE) begin
      svc_cond = (level >= (FIFO_FULL_COUNT - eff_thr));
    end else begin
      svc_cond = (level <= eff_thr);
    end
  end

  // FIFO source: peripheral in reverse, host writes in forward
  always_comb begin
    if (DIRECTION_REVERSE) begin
      fifo_in_data = PERIPH_DATA;
      fifo_in_valid = PERIPH_VALID && periph_ready;
    end else begin
      fifo_in_data = HOST_WDATA;
      fifo_in_valid = host_data_wr || host_cmd_wr;
    end
    fifo_out_ready = DIRECTION_REVERSE ? (host_data_rd || (dack && HOST_RD)) : FWD_READY;
  end

  efs_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .clear(1'b0),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .count(fifo_count)
  );

  // Marks a command-offset entry only when it is written into an empty forward FIFO
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmd_pending <= 1'b0;
    end else if (!DIRECTION_REVERSE && host_cmd_wr && fifo_count == '0) begin
      cmd_pending <= 1'b1;
    end else if (!DIRECTION_REVERSE && fifo_out_valid && FWD_READY) begin
      cmd_pending <= 1'b0;
    end
  end

  // Configuration key sequence, index and data
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_mode <= 1'b0;
      key_seen <= 1'b0;
      cfg_index <= 8'h00;
      port_mode_control <= PORT_MODE_CONTROL_RST;
    end else if (HOST_WR && HOST_ADDR == CFG_INDEX_OFS) begin
      if (!cfg_mode) begin
        key_seen <= (HOST_WDATA == CFG_ENTER_KEY);
        cfg_mode <= key_seen && (HOST_WDATA == CFG_ENTER_KEY);
      end else if (HOST_WDATA == CFG_EXIT_KEY) begin
        cfg_mode <= 1'b0;
        key_seen <= 1'b0;
      end else begin
        cfg_index <= HOST_WDATA;
      end
    end else if (HOST_WR && HOST_ADDR == CFG_DATA_OFS && cfg_mode) begin
      if (cfg_index == IDX_PORT_MODE_CONTROL) begin
        port_mode_control <= HOST_WDATA;
      end
    end else if (HOST_WR && !cfg_mode) begin
      key_seen <= 1'b0;
    end
  end

  // Host read data
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HOST_RDATA <= 8'h00;
    end else if (HOST_RD && HOST_ADDR == CFG_DATA_OFS && cfg_mode) begin
      HOST_RDATA <= cfg_read(cfg_index, port_mode_control);
    end else if (host_data_rd || (dack && HOST_RD)) begin
      HOST_RDATA <= fifo_out_valid ? fifo_out_data : 8'h00;
    end else if (HOST_RD) begin
      HOST_RDATA <= 8'h00;
    end
  end

  // Service mask: software set/clear, terminal count sets it
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      service_irq_mask <= 1'b1;
      tc_block <= 1'b0;
    end else begin
      if (tc_hit && DMA_TRANSFER_ENABLE) begin
        service_irq_mask <= 1'b1;
        tc_block <= 1'b1;
      end else if (SERVICE_IRQ_MASK_SET) begin
        service_irq_mask <= 1'b1;
      end else if (SERVICE_IRQ_MASK_CLR) begin
        service_irq_mask <= 1'b0;
        tc_block <= 1'b0;
      end
    end
  end

  // Burst limit and acknowledge idle time
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dack_q <= 1'b0;
      burst_cnt <= 6'h00;
      burst_hold <= 1'b0;
      idle_cnt <= 8'h00;
    end else begin
      dack_q <= dack;
      if (dack && !dack_q) begin
        burst_cnt <= burst_cnt + 6'h01;
        if (burst_cnt + 6'h01 >= DMA_BURST_MAX) begin
          burst_hold <= 1'b1;
        end
      end
      if (dack) begin
        idle_cnt <= 8'h00;
      end else if (burst_hold) begin
        if (idle_cnt >= 8'(DACK_IDLE_CYC - 1)) begin
          burst_hold <= 1'b0;
          burst_cnt <= 6'h00;
        end else begin
          idle_cnt <= idle_cnt + 8'h01;
        end
      end
    end
  end

  // DMA request
  always_comb begin
    dma_dreq = DIRECTION_REVERSE && DMA_TRANSFER_ENABLE && !service_irq_mask
      && !tc_block && !burst_hold && fifo_out_valid;
    if (tc_hit) begin
      dma_dreq = 1'b0;
    end
    if (level == 5'h01 && (dack || HOST_RD)) begin
      dma_dreq = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DMA_REQUEST_OUT <= 1'b0;
    end else begin
      DMA_REQUEST_OUT <= dma_dreq;
    end
  end

  // Port interrupt: pulsed low then released, or follows ACK
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      svc_q <= 1'b0;
      ack_q <= 1'b1;
      pulse_cnt <= 3'h0;
      PORT_INTERRUPT_OUT <= 1'b1;
      PORT_INTERRUPT_OE <= 1'b0;
    end else begin
      svc_q <= svc_cond && !service_irq_mask && !DMA_TRANSFER_ENABLE;
      ack_q <= ACK_N;
      if (port_mode_control[IRQ_TYPE_BIT]
          && port_mode_control[MODE_MSB:MODE_LSB] != EFS_MODE_PRINTER
          && port_mode_control[MODE_MSB:MODE_LSB] != EFS_MODE_SPP) begin
        if ((svc_cond && !service_irq_mask && !DMA_TRANSFER_ENABLE && !svc_q)
            || (tc_hit && DMA_TRANSFER_ENABLE && !service_irq_mask)) begin
          pulse_cnt <= 3'(IRQ_PULSE_CYC);
          PORT_INTERRUPT_OUT <= 1'b0;
          PORT_INTERRUPT_OE <= 1'b1;
        end else if (pulse_cnt > 3'h1) begin
          pulse_cnt <= pulse_cnt - 3'h1;
        end else begin
          pulse_cnt <= 3'h0;
          PORT_INTERRUPT_OUT <= 1'b1;
          PORT_INTERRUPT_OE <= 1'b0;
        end
      end else begin
        pulse_cnt <= 3'h0;
        PORT_INTERRUPT_OUT <= ack_q;
        PORT_INTERRUPT_OE <= 1'b1;
      end
    end
  end

  // Registered peripheral ready, mask and mode outputs
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      periph_ready <= 1'b0;
      SERVICE_IRQ_MASK <= 1'b1;
      PORT_MODE <= PORT_MODE_CONTROL_RST[MODE_MSB:MODE_LSB];
    end else begin
      periph_ready <= DIRECTION_REVERSE && fifo_in_ready;
      SERVICE_IRQ_MASK <= service_irq_mask;
      PORT_MODE <= port_mode_control[MODE_MSB:MODE_LSB];
    end
  end

  assign PERIPH_READY = periph_ready && fifo_in_ready;
  assign FWD_DATA = fifo_out_data;
  assign FWD_VALID = !DIRECTION_REVERSE && fifo_out_valid;
  assign FWD_IS_COMMAND = cmd_pending;
endmodule // efs_service

/* verif/efs_service_asserts.sv */
// Port checker for the FIFO service block
`timescale 1ns/100ps
module efs_service_asserts (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic HOST_RD,
  input wire logic [7:0] HOST_RDATA,
  input wire logic DMA_ACKNOWLEDGE_N,
  input wire logic TERMINAL_COUNT_IN,
  input wire logic DMA_REQUEST_OUT,
  input wire logic DMA_TRANSFER_ENABLE,
  input wire logic SERVICE_IRQ_MASK,
  input wire logic DIRECTION_REVERSE,
  input wire logic ACK_N,
  input wire logic PORT_INTERRUPT_OUT,
  input wire logic PORT_INTERRUPT_OE,
  input wire logic [2:0] PORT_MODE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  a_reset_state: assert property ($rose(ARST_N) |-> PORT_MODE == 3'b111 && SERVICE_IRQ_MASK)
    else $error("mode or mask wrong after reset");
  a_mask_blocks_req: assert property (SERVICE_IRQ_MASK && $past(SERVICE_IRQ_MASK) |-> !DMA_REQUEST_OUT)
    else $error("request while masked");
  a_tc_sets_mask: assert property (!DMA_ACKNOWLEDGE_N && TERMINAL_COUNT_IN && DMA_TRANSFER_ENABLE |-> ##2 SERVICE_IRQ_MASK)
    else $error("terminal count left mask clear");
  a_tc_ends_req: assert property (!DMA_ACKNOWLEDGE_N && TERMINAL_COUNT_IN |-> ##2 !DMA_REQUEST_OUT)
    else $error("request kept after terminal count");
  a_fwd_no_req: assert property (!DIRECTION_REVERSE && !$past(DIRECTION_REVERSE) |-> !DMA_REQUEST_OUT)
    else $error("request in forward direction");
  a_pio_no_req: assert property (!DMA_TRANSFER_ENABLE && !$past(DMA_TRANSFER_ENABLE) |-> !DMA_REQUEST_OUT)
    else $error("request with DMA disabled");
  a_irq_pulse_len: assert property ($fell(PORT_INTERRUPT_OUT) && $past(ACK_N, 2) |->
    (!PORT_INTERRUPT_OUT && PORT_INTERRUPT_OE) [*4] ##1 !PORT_INTERRUPT_OE)
    else $error("interrupt pulse shape wrong");
  a_rdata_holds: assert property (!HOST_RD |=> $stable(HOST_RDATA))
    else $error("read data changed without read");
  c_dma_req: cover property ($rose(DMA_REQUEST_OUT));
  c_tc_seen: cover property (!DMA_ACKNOWLEDGE_N && TERMINAL_COUNT_IN);
  c_irq_seen: cover property ($fell(PORT_INTERRUPT_OUT));
endmodule // efs_service_asserts

bind efs_service efs_service_asserts u_chk (
  .CORE_CLK(CORE_CLK),
  .ARST_N(ARST_N),
  .HOST_RD(HOST_RD),
  .HOST_RDATA(HOST_RDATA),
  .DMA_ACKNOWLEDGE_N(DMA_ACKNOWLEDGE_N),
  .TERMINAL_COUNT_IN(TERMINAL_COUNT_IN),
  .DMA_REQUEST_OUT(DMA_REQUEST_OUT),
  .DMA_TRANSFER_ENABLE(DMA_TRANSFER_ENABLE),
  .SERVICE_IRQ_MASK(SERVICE_IRQ_MASK),
  .DIRECTION_REVERSE(DIRECTION_REVERSE),
  .ACK_N(ACK_N),
  .PORT_INTERRUPT_OUT(PORT_INTERRUPT_OUT),
  .PORT_INTERRUPT_OE(PORT_INTERRUPT_OE),
  .PORT_MODE(PORT_MODE)
);

/* verif/efs_dma_host.sv */
// Host DMA controller model answering the request line
`timescale 1ns/100ps
module efs_dma_host (
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] gap,
  input wire logic [7:0] tc_at,
  input wire logic req,
  output logic ack_n,
  output logic rd,
  output logic tc,
  output logic [7:0] taken
);
  logic [3:0] wait_cnt;
  initial {ack_n, rd, tc} = 3'b100;
  // One acknowledged read per request, then a settle gap
  always @(posedge clk) begin
    rd <= 1'b0;
    tc <= 1'b0;
    ack_n <= 1'b1;
    if (!go) begin
      taken <= 8'h00;
      wait_cnt <= 4'h0;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (req) begin
      ack_n <= 1'b0;
      rd <= 1'b1;
      tc <= (taken + 8'h01 == tc_at);
      taken <= taken + 8'h01;
      wait_cnt <= 4'h3 + {1'b0, gap};
    end
  end
endmodule // efs_dma_host

/* verif/ecp_fifo_service_and_config_bench.sv */
// Self-checking bench for the FIFO service block
`timescale 1ns/100ps
module ecp_fifo_service_and_config_bench import efs_pkg::*;;
  logic clk, arst_n, wr, hrd, mset, mclr, dma_en, rev, pv, fr, go, drd, dack_n, dtc, h, ackn;
  logic [10:0] addr;
  logic [7:0] wd, rdata, pd, fdata, tc_at, taken, v;
  logic [2:0] mode, gap;
  logic req, mask, irq, irq_oe, pready, fv, fcmd;
  int mismatches, samples_checked, i;
  efs_service #(.FIFO_WORDS(8)) uut (.CORE_CLK(clk), .ARST_N(arst_n), .HOST_ADDR(addr),
    .HOST_WDATA(wd), .HOST_WR(wr), .HOST_RD(hrd | drd), .HOST_RDATA(rdata),
    .DMA_ACKNOWLEDGE_N(dack_n), .TERMINAL_COUNT_IN(dtc), .DMA_REQUEST_OUT(req),
    .DMA_TRANSFER_ENABLE(dma_en), .SERVICE_IRQ_MASK_CLR(mclr), .SERVICE_IRQ_MASK_SET(mset),
    .SERVICE_IRQ_MASK(mask), .DIRECTION_REVERSE(rev), .ACK_N(ackn),
    .PORT_INTERRUPT_OUT(irq), .PORT_INTERRUPT_OE(irq_oe), .PERIPH_DATA(pd),
    .PERIPH_VALID(pv), .PERIPH_READY(pready), .FWD_DATA(fdata), .FWD_VALID(fv),
    .FWD_IS_COMMAND(fcmd), .FWD_READY(fr), .PORT_MODE(mode));
  efs_dma_host dma (.clk(clk), .go(go), .gap(gap), .tc_at(tc_at), .req(req),
    .ack_n(dack_n), .rd(drd), .tc(dtc), .taken(taken));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hw(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk) addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic hr(input logic [10:0] a, output logic [7:0] d);
    @(posedge clk) addr <= a;
    hrd <= 1'b1;
    @(posedge clk) hrd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cfg(input logic [7:0] idx, input logic [7:0] e);
    hw(CFG_INDEX_OFS, idx);
    hr(CFG_DATA_OFS, v);
    chk(v, e);
  endtask
  task automatic key;
    hw(CFG_INDEX_OFS, CFG_ENTER_KEY);
    hw(CFG_INDEX_OFS, CFG_ENTER_KEY);
  endtask
  task automatic setf0(input logic [7:0] d);
    key();
    hw(CFG_INDEX_OFS, IDX_PORT_MODE_CONTROL);
    hw(CFG_DATA_OFS, d);
    hw(CFG_INDEX_OFS, CFG_EXIT_KEY);
  endtask
  // Direction, DMA enable and a mask set or clear pulse
  task automatic svc(input logic r, input logic e, input logic s);
    @(posedge clk) rev <= r;
    dma_en <= e;
    addr <= DATA_FIFO_OFS;
    mset <= s;
    mclr <= !s;
    @(posedge clk) mset <= 1'b0;
    mclr <= 1'b0;
  endtask
  task automatic push(input logic [7:0] d);
    @(posedge clk) pd <= d;
    pv <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      end_sim();
    end
    @(posedge clk) pv <= 1'b0;
  endtask
  task automatic pop(input logic [7:0] e);
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (fv === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      end_sim();
    end
    chk(fdata, e);
    @(posedge clk) fr <= 1'b1;
    @(posedge clk) fr <= 1'b0;
  endtask
  task automatic irqw(input logic e);
    h = 1'b0;
    repeat (8) begin
      @(negedge clk);
      if (irq === 1'b0) h = 1'b1;
    end
    chk({7'h0, h}, {7'h0, e});
  endtask
  task automatic wtk(input logic [7:0] n);
    for (i = 0; i < 80 && taken !== n; i++) @(posedge clk);
    if (i == 80) begin
      mismatches++;
      end_sim();
    end
    chk(taken, n);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {arst_n, wr, hrd, mset, mclr, dma_en, rev, pv, fr, go} = '0;
    {addr, wd, pd, tc_at, gap} = '0;
    ackn = 1'b1;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    #1 chk({3'h0, mask, req, mode}, 8'h17);
    @(posedge clk) ackn <= 1'b0;
    repeat (3) @(negedge clk);
    chk({6'h0, irq, irq_oe}, 8'h01);
    @(posedge clk) ackn <= 1'b1;
    key();
    cfg(IDX_PORT_MODE_CONTROL, PORT_MODE_CONTROL_RST);
    for (int m = 0; m < 8; m++) begin
      if (m != 6) begin
        hw(CFG_DATA_OFS, {5'b11011, m[2:0]});
        repeat (2) @(negedge clk);
        chk({5'h0, mode}, m[7:0]);
      end
    end
    hw(CFG_DATA_OFS, 8'hda);
    cfg(IDX_PORT_MODE_CONTROL, 8'hda);
    cfg(IDX_CHIP_IDENT_FIRST, CHIP_IDENT_FIRST_VAL);
    hw(CFG_DATA_OFS, 8'h00);
    cfg(IDX_CHIP_IDENT_FIRST, CHIP_IDENT_FIRST_VAL);
    cfg(IDX_CHIP_IDENT_SECOND, CHIP_IDENT_SECOND_VAL);
    hw(CFG_DATA_OFS, 8'hff);
    cfg(IDX_CHIP_IDENT_SECOND, CHIP_IDENT_SECOND_VAL);
    cfg(8'h22, 8'h00);
    hw(CFG_DATA_OFS, 8'h55);
    cfg(IDX_PORT_MODE_CONTROL, 8'hda);
    hw(CFG_INDEX_OFS, CFG_EXIT_KEY);
    hr(CFG_DATA_OFS, v);
    chk(v, 8'h00);
    svc(1'b1, 1'b0, 1'b0);
    for (int b = 1; b < 4; b++) push(b[7:0]);
    irqw(1'b0);
    push(8'h04);
    irqw(1'b1);
    for (int b = 1; b < 5; b++) begin
      hr(DATA_FIFO_OFS, v);
      chk(v, b[7:0]);
    end
    svc(1'b1, 1'b0, 1'b1);
    setf0(8'hfa);
    svc(1'b1, 1'b0, 1'b0);
    irqw(1'b0);
    push(8'h55);
    irqw(1'b1);
    svc(1'b1, 1'b0, 1'b1);
    svc(1'b1, 1'b0, 1'b0);
    irqw(1'b1);
    hr(DATA_FIFO_OFS, v);
    chk(v, 8'h55);
    svc(1'b0, 1'b0, 1'b1);
    setf0(8'h8a);
    for (int b = 1; b < 4; b++) hw(DATA_FIFO_OFS, 8'ha0 + b[7:0]);
    svc(1'b0, 1'b0, 1'b0);
    irqw(1'b0);
    pop(8'ha1);
    irqw(1'b1);
    pop(8'ha2);
    pop(8'ha3);
    hw(CMD_FIFO_OFS, 8'h81);
    @(negedge clk) chk({7'h0, fcmd}, 8'h01);
    pop(8'h81);
    svc(1'b1, 1'b1, 1'b0);
    go <= 1'b1;
    for (int b = 0; b < 5; b++) push(b[7:0]);
    wtk(8'h05);
    @(negedge clk) chk({7'h0, req}, 8'h00);
    @(posedge clk) go <= 1'b0;
    @(posedge clk) go <= 1'b1;
    tc_at <= 8'h02;
    gap <= 3'h5;
    for (int b = 0; b < 3; b++) push(b[7:0]);
    wtk(8'h02);
    repeat (30) @(posedge clk);
    chk({6'h0, mask, req}, 8'h02);
    chk(taken, 8'h02);
    svc(1'b1, 1'b1, 1'b0);
    wtk(8'h03);
    end_sim();
  end
endmodule // ecp_fifo_service_and_config_bench
